// File: verilog/dchcfg_top.sv
// digital output channel configuration: registers, ratio decode, four channels
// Notes on behaviour
// - each channel divides its source by prescaler ratio times lower-stage ratio.
// - prescaler code n gives two to the n; codes 7 to 15 are reserved.
// - prescaler code 6 (divide by 64) turns on the extended stage.
// - lower code gives 1,2,3,4,5,9,15,25; multiplies prescaler ratio.
// - nine-bit phase delay in half source periods, 0 none, 511 most.
// - phase step follows the source that the channel currently selects.
// - power-off bit stops the channel divider and its drivers.
// - outputs 0 and 1 take source 0 or 1; codes 2 and 3 reserved.
// - outputs 2 and 3 take sources 0, 1 or 2; code 3 reserved.
// - a 21-bit extended divider extends a channel division further only at prescaler code 6.
// - total is prescaler times lower times extended; ext 0 is 1, n is 2n.
// - one extended value for outputs 0 and 1, another for 2 and 3.
`timescale 1ns/10ps
`include "dchcfg_defs.svh"
module dchcfg_top (
  input  wire logic        i_clock,          // system clock, 250 MHz
  input  wire logic        i_nrst,           // async reset, active low
  input  wire logic [2:0]  i_src_tick,       // half-period strobes: loop, eth2, radio
  input  wire logic [15:0] i_reg_addr,       // register byte address
  input  wire logic [7:0]  i_reg_wdata,      // register write data
  input  wire logic        i_reg_wr,         // register write strobe
  output logic      [7:0]  o_reg_rdata,      // read data of last cycle's address
  output logic      [3:0]  o_digital_out,    // digital_out0..3
  output logic      [3:0]  o_drv_power_off,  // channel_power_off to drivers
  output logic      [3:0]  o_ext_stage_on    // extended stage active per channel
);
  logic [6:0]  ratio_r [4];
  logic [8:0]  phase_r [4];
  logic        pd_r    [4];
  logic [1:0]  src_r   [4];
  logic [20:0] ext_r   [2];
  logic [3:0]  restart_r;
  logic [3:0]  chan_en;
  logic [3:0]  chan_tick;
  logic [7:0]  rd_nxt;

  dchcfg_chan_if cif [4] ();

  // ***************************************************
  // decode helpers
  // ***************************************************
  function automatic logic [15:0] chan_base(input logic [1:0] idx);
    unique case (idx)
      2'h0: chan_base = `DCHCFG_BASE_D0;
      2'h1: chan_base = `DCHCFG_BASE_D1;
      2'h2: chan_base = `DCHCFG_BASE_D2;
      2'h3: chan_base = `DCHCFG_BASE_D3;
    endcase
  endfunction : chan_base

  function automatic logic [15:0] ext_base(input logic idx);
    ext_base = idx ? `DCHCFG_EXT_HIGH : `DCHCFG_EXT_LOW;
  endfunction : ext_base

  function automatic logic src_ok(input logic [1:0] idx, input logic [1:0] src);
    src_ok = idx[1] ? (src != 2'h3) : (src[1] == 1'b0);
  endfunction : src_ok

  function automatic dchcfg_pkg::dchcfg_ratio_t total_ratio(input logic [6:0]  n,
                                                            input logic [20:0] ext);
    logic [6:0]  pre;
    logic [4:0]  low;
    logic [21:0] ex;
    // codes above six are held off by the enable logic, so three bits suffice here
    pre = 7'h01 << n[`DCHCFG_PRE_LSB +: 3];
    unique case (n[2:0])
      3'h0: low = 5'h01;
      3'h1: low = 5'h02;
      3'h2: low = 5'h03;
      3'h3: low = 5'h04;
      3'h4: low = 5'h05;
      3'h5: low = 5'h09;
      3'h6: low = 5'h0f;
      3'h7: low = 5'h19;
    endcase
    if (n[6:`DCHCFG_PRE_LSB] != `DCHCFG_PRE_X64) begin
      ex = 22'h1;
    end else if (ext == '0) begin
      ex = 22'h1;
    end else begin
      ex = {ext, 1'b0};
    end
    // widest product, 64 x 25 x 2 x (2^21 - 1), still fits in 34 bits
    total_ratio = 34'(pre) * 34'(low) * 34'(ex);
  endfunction : total_ratio

  // ***************************************************
  // channel register writes
  // ***************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ratio_r[0] <= `DCHCFG_RATIO_RST_D0;
      ratio_r[1] <= `DCHCFG_RATIO_RST_D1;
      ratio_r[2] <= `DCHCFG_RATIO_RST_D2;
      ratio_r[3] <= `DCHCFG_RATIO_RST_D3;
      phase_r[0] <= `DCHCFG_PHASE_RST_D0;
      phase_r[1] <= `DCHCFG_PHASE_RST_D1;
      phase_r[2] <= `DCHCFG_PHASE_RST_D2;
      phase_r[3] <= `DCHCFG_PHASE_RST_D3;
      for (int i = 0; i < 4; i++) begin
        pd_r[i]  <= 1'b0;
        src_r[i] <= `DCHCFG_SRC_LOOP;
      end
    end else if (i_reg_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (i_reg_addr == (chan_base(2'(i)) | `DCHCFG_OFF_B0)) begin
          ratio_r[i] <= i_reg_wdata[6:0];
        end
        if (i_reg_addr == (chan_base(2'(i)) | `DCHCFG_OFF_B1)) begin
          phase_r[i][8:1] <= i_reg_wdata;
        end
        if (i_reg_addr == (chan_base(2'(i)) | `DCHCFG_OFF_B2)) begin
          pd_r[i]         <= i_reg_wdata[`DCHCFG_PD_BIT];
          src_r[i]        <= i_reg_wdata[`DCHCFG_SRC_LSB +: 2];
          phase_r[i][0]   <= i_reg_wdata[0];
        end
      end
    end
  end

  // ***************************************************
  // shared extended divider writes
  // ***************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_r[0] <= `DCHCFG_EXT_RST;
      ext_r[1] <= `DCHCFG_EXT_RST;
    end else if (i_reg_wr) begin
      for (int j = 0; j < 2; j++) begin
        if (i_reg_addr == (ext_base(1'(j)) | `DCHCFG_OFF_B0)) begin
          ext_r[j][7:0] <= i_reg_wdata;
        end
        if (i_reg_addr == (ext_base(1'(j)) | `DCHCFG_OFF_B1)) begin
          ext_r[j][15:8] <= i_reg_wdata;
        end
        if (i_reg_addr == (ext_base(1'(j)) | `DCHCFG_OFF_B2)) begin
          ext_r[j][20:16] <= i_reg_wdata[4:0];
        end
      end
    end
  end

  // ***************************************************
  // restart: any write to a channel or its shared extension
  // ***************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      restart_r <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // no atomic update: a multi-byte change runs briefly on a half-written value
        restart_r[i] <= i_reg_wr &&
          ((i_reg_addr & 16'hfffc) == chan_base(2'(i)) ||
           (i_reg_addr & 16'hfffc) == ext_base(1'(i / 2)));
      end
    end
  end

  // ***************************************************
  // read back, one cycle after the address
  // ***************************************************
  always_comb begin
    // byte 3 of each group and every unmapped address read as zero
    rd_nxt = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (i_reg_addr == (chan_base(2'(i)) | `DCHCFG_OFF_B0)) begin
        rd_nxt = {1'b0, ratio_r[i]};
      end
      if (i_reg_addr == (chan_base(2'(i)) | `DCHCFG_OFF_B1)) begin
        rd_nxt = phase_r[i][8:1];
      end
      if (i_reg_addr == (chan_base(2'(i)) | `DCHCFG_OFF_B2)) begin
        rd_nxt = {pd_r[i], 4'h0, src_r[i], phase_r[i][0]};
      end
    end
    for (int j = 0; j < 2; j++) begin
      if (i_reg_addr == (ext_base(1'(j)) | `DCHCFG_OFF_B0)) begin
        rd_nxt = ext_r[j][7:0];
      end
      if (i_reg_addr == (ext_base(1'(j)) | `DCHCFG_OFF_B1)) begin
        rd_nxt = ext_r[j][15:8];
      end
      if (i_reg_addr == (ext_base(1'(j)) | `DCHCFG_OFF_B2)) begin
        rd_nxt = {3'h0, ext_r[j][20:16]};
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rd_nxt;
    end
  end

  // ***************************************************
  // channel enable and source steering
  // ***************************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // a reserved source or prescaler holds the channel off rather than guess
      chan_en[i] = !pd_r[i] && src_ok(2'(i), src_r[i]) &&
                   ratio_r[i][6:`DCHCFG_PRE_LSB] <= `DCHCFG_PRE_X64;
      chan_tick[i] = src_ok(2'(i), src_r[i]) && i_src_tick[src_r[i]];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_drv_power_off <= '0;
      o_ext_stage_on  <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        o_drv_power_off[i] <= pd_r[i];
        o_ext_stage_on[i]  <= ratio_r[i][6:`DCHCFG_PRE_LSB] == `DCHCFG_PRE_X64;
      end
    end
  end

  // ***************************************************
  // channels
  // ***************************************************
  for (genvar g = 0; g < 4; g++) begin : g_chan
    assign cif[g].restart  = restart_r[g];
    assign cif[g].enable   = chan_en[g];
    assign cif[g].tick     = chan_tick[g];
    assign cif[g].ratio    = total_ratio(ratio_r[g], ext_r[g / 2]);
    assign cif[g].phase    = phase_r[g];
    assign o_digital_out[g] = cif[g].out;

    dchcfg_chan u_chan (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .cif     (cif[g])
    );
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  AST_EXT_ON: assert property (
    ##1 o_ext_stage_on[0] == ($past(ratio_r[0][6:3]) == 4'h6))
    else $error("extended stage flag wrong for output 0");
  AST_EXT_ON_D3: assert property (
    ##1 o_ext_stage_on[3] == ($past(ratio_r[3][6:3]) == 4'h6))
    else $error("extended stage flag wrong for output 3");
  AST_D01_RESERVED: assert property (src_r[1][1] |-> !chan_en[1])
    else $error("output 1 runs on a reserved source");
  AST_D23_RADIO: assert property (
    src_r[2] == 2'h2 && !pd_r[2] && ratio_r[2][6:3] <= 4'h6
    |-> chan_en[2] && chan_tick[2] == i_src_tick[2])
    else $error("output 2 not steered to the radio source");
  AST_PRE_RESERVED: assert property (ratio_r[3][6:3] > 4'h6 |=> !o_digital_out[3])
    else $error("reserved prescaler left output 3 running");
  AST_EXT_SHARED: assert property (
    i_reg_wr && i_reg_addr == 16'h02b4 |=> restart_r[0] && restart_r[1] && !restart_r[2])
    else $error("low pair extension did not restart outputs 0 and 1 only");
  AST_RATIO_X64: assert property (
    ratio_r[0] == 7'h37 |-> cif[0].ratio ==
      (ext_r[0] == '0 ? 34'(64 * 25) : 34'(64 * 25 * 2) * 34'(ext_r[0])))
    else $error("total ratio for 64 times 25 wrong");
  AST_POWER_DRV: assert property (pd_r[2] |=> o_drv_power_off[2] && !o_digital_out[2])
    else $error("power-off did not stop output 2");

  // ***************************************************
  // ratio decode, steering, driver power-off and extension restart spot checks
  // ***************************************************
  sequence s_high_ext_write;
    i_reg_wr && (i_reg_addr & 16'hfffc) == `DCHCFG_EXT_HIGH;
  endsequence

  AST_RATIO_LOW9: assert property (ratio_r[1] == 7'h05 |-> cif[1].ratio == 34'h9)
    else $error("lower code 5 does not divide by 9");

  AST_RATIO_LOW25: assert property (ratio_r[3] == 7'h07 |-> cif[3].ratio == 34'h19)
    else $error("lower code 7 does not divide by 25");

  AST_RATIO_POW2: assert property (ratio_r[2] == 7'h11 |-> cif[2].ratio == 34'h8)
    else $error("prescaler code 2 with lower code 1 does not divide by 8");

  AST_RATIO_UNITY: assert property (ratio_r[0] == 7'h00 |-> cif[0].ratio == 34'h1)
    else $error("unity codes did not give a ratio of one");

  AST_D0_ETH2: assert property (src_r[0] == 2'h1 |-> chan_tick[0] == i_src_tick[1])
    else $error("output 0 not steered to the second synthesizer");

  AST_D1_LOOP: assert property (src_r[1] == 2'h0 |-> chan_tick[1] == i_src_tick[0])
    else $error("output 1 not steered to the first loop");

  AST_D3_RESERVED: assert property (src_r[3] == 2'h3 |-> !chan_en[3])
    else $error("output 3 runs on a reserved source");

  AST_DRV_ALL: assert property (
    ##1 o_drv_power_off ==
      {$past(pd_r[3]), $past(pd_r[2]), $past(pd_r[1]), $past(pd_r[0])})
    else $error("driver power-off does not follow the channel bits");

  AST_HIGH_EXT_SHARED: assert property (
    s_high_ext_write |=> restart_r[2] && restart_r[3] && !restart_r[0] && !restart_r[1])
    else $error("high pair extension did not restart outputs 2 and 3 only");
endmodule : dchcfg_top

// File: verilog/dchcfg_defs.svh
// constants for the digital output channel configuration block
`ifndef DCHCFG_DEFS_SVH
`define DCHCFG_DEFS_SVH

// ***************************************************
// register byte addresses
// ***************************************************
`define DCHCFG_BASE_D0      16'h02b8
`define DCHCFG_BASE_D1      16'h02b0
`define DCHCFG_BASE_D2      16'h02a8
`define DCHCFG_BASE_D3      16'h02a0
`define DCHCFG_EXT_LOW      16'h02b4
`define DCHCFG_EXT_HIGH     16'h02a4
`define DCHCFG_OFF_B0       16'h0000
`define DCHCFG_OFF_B1       16'h0001
`define DCHCFG_OFF_B2       16'h0002

// ***************************************************
// field positions and codes
// ***************************************************
`define DCHCFG_PD_BIT       7
`define DCHCFG_SRC_LSB      1
`define DCHCFG_PRE_LSB      3
`define DCHCFG_PRE_X64      4'h6
`define DCHCFG_SRC_LOOP     2'h0
`define DCHCFG_SRC_ETH2     2'h1
`define DCHCFG_SRC_RADIO    2'h2

// ***************************************************
// reset values
// ***************************************************
`define DCHCFG_RATIO_RST_D0 7'h0f
`define DCHCFG_RATIO_RST_D1 7'h14
`define DCHCFG_RATIO_RST_D2 7'h0b
`define DCHCFG_RATIO_RST_D3 7'h07
`define DCHCFG_PHASE_RST_D0 9'h000
`define DCHCFG_PHASE_RST_D1 9'h00a
`define DCHCFG_PHASE_RST_D2 9'h00a
`define DCHCFG_PHASE_RST_D3 9'h000
`define DCHCFG_EXT_RST      21'h000000

`endif

// File: verilog/dchcfg_pkg.sv
// types shared by the digital output channel configuration block
package dchcfg_pkg;
  typedef logic [33:0] dchcfg_ratio_t;
  typedef logic [8:0]  dchcfg_phase_t;
  typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_RUN} dchcfg_state_e;
endpackage : dchcfg_pkg

// File: verilog/dchcfg_chan_if.sv
// settings and output of one digital output channel
`timescale 1ns/10ps
interface dchcfg_chan_if;
  logic                     restart;
  logic                     enable;
  logic                     tick;
  dchcfg_pkg::dchcfg_ratio_t ratio;
  dchcfg_pkg::dchcfg_phase_t phase;
  logic                     out;
  modport cfg  (output restart, enable, tick, ratio, phase, input out);
  modport chan (input restart, enable, tick, ratio, phase, output out);
endinterface : dchcfg_chan_if

// File: verilog/dchcfg_chan.sv
// one digital output channel: phase delay then divide by the total ratio
`timescale 1ns/10ps
module dchcfg_chan (
  input  wire logic    i_clock,  // system clock
  input  wire logic    i_nrst,   // async reset, active low
  dchcfg_chan_if.chan  cif       // settings from the register file
);
  dchcfg_pkg::dchcfg_state_e state_r;
  dchcfg_pkg::dchcfg_ratio_t ratio_r;
  dchcfg_pkg::dchcfg_ratio_t cnt_r;
  logic                      load;
  logic                      step;

  assign load = cif.enable && (cif.restart || state_r == dchcfg_pkg::ST_OFF);
  assign step = cif.enable && !load && cif.tick && cnt_r == '0;

  // ***************************************************
  // ratio latch
  // ***************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ratio_r <= 34'h1;
    end else if (load) begin
      ratio_r <= cif.ratio;
    end
  end

  // ***************************************************
  // sequencer: one count per half period of the source
  // ***************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= dchcfg_pkg::ST_OFF;
      cnt_r   <= '0;
    end else if (!cif.enable) begin
      state_r <= dchcfg_pkg::ST_OFF;
      cnt_r   <= '0;
    end else if (load) begin
      state_r <= dchcfg_pkg::ST_DELAY;
      cnt_r   <= 34'(cif.phase);
    end else if (cif.tick) begin
      if (cnt_r == '0) begin
        state_r <= dchcfg_pkg::ST_RUN;
        cnt_r   <= ratio_r - 34'h1;
      end else begin
        cnt_r <= cnt_r - 34'h1;
      end
    end
  end

  // ***************************************************
  // output level
  // ***************************************************
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cif.out <= 1'b0;
    end else if (!cif.enable || load) begin
      cif.out <= 1'b0;
    end else if (step) begin
      cif.out <= (state_r == dchcfg_pkg::ST_DELAY) ? 1'b1 : !cif.out;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_delay_spent;
    state_r == dchcfg_pkg::ST_DELAY && cnt_r == '0;
  endsequence
  sequence s_first_tick;
    cif.enable && !cif.restart && cif.tick;
  endsequence

  AST_CHAN_OFF_LOW: assert property (!cif.enable |=> !cif.out)
    else $error("output not low while channel is off");
  AST_PHASE_ZERO: assert property (s_delay_spent and s_first_tick |=> cif.out)
    else $error("output did not rise when the phase delay ran out");
  AST_DELAY_LOW: assert property (state_r == dchcfg_pkg::ST_DELAY |-> !cif.out)
    else $error("output high during phase delay");
  AST_EDGE_ON_TICK: assert property (
    $changed(cif.out) && $past(cif.enable) && !$past(cif.restart) |-> $past(cif.tick))
    else $error("output moved without a source tick");
  AST_DIV_ONE: assert property (
    (state_r == dchcfg_pkg::ST_RUN && ratio_r == 34'h1) and s_first_tick
    |=> $changed(cif.out))
    else $error("ratio one did not toggle on each tick");
endmodule : dchcfg_chan

// File: bench/dchcfg_top_test.sv
// self-checking bench for the digital output channel configuration block
`timescale 1ns/10ps
`include "dchcfg_defs.svh"
module dchcfg_top_test;
  logic        i_clock;
  logic        i_nrst;
  logic [2:0]  i_src_tick;
  logic [15:0] i_reg_addr;
  logic [7:0]  i_reg_wdata;
  logic        i_reg_wr;
  logic [7:0]  o_reg_rdata;
  logic [3:0]  o_digital_out;
  logic [3:0]  o_drv_power_off;
  logic [3:0]  o_ext_stage_on;
  int          fail_count;
  int          checked;
  logic [3:0]  pd_m;
  logic [3:0]  x64_m;
  int          low_tab [8] = '{1, 2, 3, 4, 5, 9, 15, 25};
  int          rst_ratio [4] = '{15, 20, 11, 7};
  int          rst_phase [4] = '{0, 10, 10, 0};

  dchcfg_top dut (
    .i_clock         (i_clock),
    .i_nrst          (i_nrst),
    .i_src_tick      (i_src_tick),
    .i_reg_addr      (i_reg_addr),
    .i_reg_wdata     (i_reg_wdata),
    .i_reg_wr        (i_reg_wr),
    .o_reg_rdata     (o_reg_rdata),
    .o_digital_out   (o_digital_out),
    .o_drv_power_off (o_drv_power_off),
    .o_ext_stage_on  (o_ext_stage_on)
  );

  always #2 i_clock = ~i_clock;

  // ***************************************************
  // reporting and register access
  // ***************************************************
  task automatic finish_test;
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [8:0] got, input logic [8:0] want);
    checked++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clock);
    i_reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    repeat (2) @(posedge i_clock);
    #1 d = o_reg_rdata;
  endtask : rd

  function automatic logic [15:0] base(input int ch);
    case (ch)
      0:       return `DCHCFG_BASE_D0;
      1:       return `DCHCFG_BASE_D1;
      2:       return `DCHCFG_BASE_D2;
      default: return `DCHCFG_BASE_D3;
    endcase
  endfunction : base

  // ***************************************************
  // configure one channel, then tick its sources and compare with the model
  // ***************************************************
  task automatic run_chan(input int ch, pre, low, ph, src, pd, ext);
    int          r;
    int          n;
    int          m;
    int          ok;
    int          nt;
    logic        want;
    logic [2:0]  tk;
    logic [7:0]  d;
    logic [15:0] b;
    logic [15:0] eb;
    b  = base(ch);
    eb = (ch < 2) ? `DCHCFG_EXT_LOW : `DCHCFG_EXT_HIGH;
    wr(eb, ext[7:0]);
    wr(eb + 16'h0001, ext[15:8]);
    wr(eb + 16'h0002, {3'h0, ext[20:16]});
    wr(b, {1'b0, pre[3:0], low[2:0]});
    wr(b + 16'h0001, ph[8:1]);
    wr(b + 16'h0002, {pd[0], 4'h0, src[1:0], ph[0]});
    pd_m[ch]  = pd[0];
    x64_m[ch] = (pre == 6);
    rd(b, d);
    chk(9'(d), {2'h0, pre[3:0], low[2:0]});
    rd(b + 16'h0001, d);
    chk(9'(d), 9'(ph[8:1]));
    rd(b + 16'h0002, d);
    chk(9'(d), {1'b0, pd[0], 4'h0, src[1:0], ph[0]});
    rd(eb, d);
    chk(9'(d), 9'(ext[7:0]));
    chk(9'(o_drv_power_off), 9'(pd_m));
    chk(9'(o_ext_stage_on), 9'(x64_m));
    ok = (pre <= 6) && (pd == 0) && (src < ((ch < 2) ? 2 : 3));
    r  = (1 << pre) * low_tab[low] * ((pre == 6) ? ((ext == 0) ? 1 : 2 * ext) : 1);
    nt = ph + 2 * r + 3;
    if (nt > 560) begin
      nt = 560;
    end
    n = 0;
    repeat (nt) begin
      tk = 3'($urandom);
      tk[src % 3] = 1'b1;
      @(posedge i_clock);
      i_src_tick <= tk;
      @(posedge i_clock);
      i_src_tick <= 3'h0;
      repeat (2) @(posedge i_clock);
      #1;
      n++;
      m    = n - ph - 1;
      want = (ok != 0) && (m >= 0) && ((m / r) % 2 == 0);
      chk(9'(o_digital_out[ch]), 9'(want));
    end
  endtask : run_chan

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    logic [7:0] d;
    i_clock     = 1'b0;
    i_nrst      = 1'b0;
    i_src_tick  = 3'h0;
    i_reg_addr  = 16'h0000;
    i_reg_wdata = 8'h00;
    i_reg_wr    = 1'b0;
    fail_count  = 0;
    checked     = 0;
    pd_m        = 4'h0;
    x64_m       = 4'h0;
    void'($urandom(32'hbff0));
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    for (int ch = 0; ch < 4; ch++) begin
      rd(base(ch), d);
      chk(9'(d), 9'(rst_ratio[ch]));
      rd(base(ch) + 16'h0001, d);
      chk(9'(d), 9'(rst_phase[ch] >> 1));
      rd(base(ch) + 16'h0002, d);
      chk(9'(d), 9'(rst_phase[ch] & 1));
    end
    for (int i = 0; i < 3; i++) begin
      rd(`DCHCFG_EXT_LOW + 16'(i), d);
      chk(9'(d), 9'h000);
      rd(`DCHCFG_EXT_HIGH + 16'(i), d);
      chk(9'(d), 9'h000);
    end
    // unmapped bytes hold nothing
    wr(base(0) + 16'h0003, 8'hff);
    rd(base(0) + 16'h0003, d);
    chk(9'(d), 9'h000);
    wr(16'h02b7, 8'h5a);
    rd(16'h02b7, d);
    chk(9'(d), 9'h000);
    for (int low = 0; low < 8; low++) begin
      run_chan(low % 4, 0, low, 0, 0, 0, 0);
    end
    for (int pre = 0; pre < 7; pre++) begin
      run_chan(pre % 4, pre, 1, $urandom % 16, 1, 0, 0);
    end
    run_chan(1, 7, 0, 0, 0, 0, 0);
    run_chan(3, 15, 0, 0, 0, 0, 0);
    run_chan(0, 6, 0, 3, 0, 0, 1);
    run_chan(0, 6, 7, 0, 1, 0, 1);
    run_chan(1, 6, 0, 0, 0, 0, 2);
    run_chan(2, 6, 0, 1, 2, 0, 0);
    run_chan(3, 6, 1, 0, 1, 0, 3);
    run_chan(3, 0, 0, 511, 0, 0, 0);
    for (int ch = 0; ch < 4; ch++) begin
      for (int src = 0; src < 4; src++) begin
        run_chan(ch, 0, 1, $urandom % 8, src, 0, 0);
      end
    end
    run_chan(2, 0, 2, 1, 2, 1, 0);
    repeat (6) begin
      run_chan($urandom % 4, $urandom % 4, $urandom % 8, $urandom % 16, $urandom % 2, 0, 0);
    end
    finish_test();
  end
endmodule : dchcfg_top_test
